// ==== rtl/acr_consts.vh ====
// acr_consts.vh - constants for the converter control and calibration
// register block: serial command layout, register selects, reset values
// and timing counts.
// assumes a 250 MHz core clock; no logic, definitions only.
`ifndef ACR_CONSTS_VH
`define ACR_CONSTS_VH

// core clock period in picoseconds (250 MHz)
`define ACR_CLK_PS         4000

// command byte layout: [7] read, [6:5] byte count - 1, [4:3] first byte,
// [2:0] register select
`define ACR_CMD_RD_BIT     7
`define ACR_CMD_CNT_HI     6
`define ACR_CMD_CNT_LO     5
`define ACR_CMD_IDX_HI     4
`define ACR_CMD_IDX_LO     3
`define ACR_CMD_REG_HI     2
`define ACR_CMD_REG_LO     0

// register selects
`define ACR_REG_CTRL       3'h4
`define ACR_REG_OFFSET     3'h5
`define ACR_REG_POSFS      3'h6
`define ACR_REG_NEGFS      3'h7

// control word fields
`define ACR_MODE_HI        11
`define ACR_MODE_LO        9
`define ACR_STANDBY_BIT    3
`define ACR_GAIN_HI        7
`define ACR_GAIN_LO        5
`define ACR_BYTE_ORDER_BIT 2

// operating mode codes
`define ACR_MODE_CONVERT   3'h0
`define ACR_MODE_SELF_CAL  3'h1
`define ACR_MODE_CAL_LAST  3'h4

// control word after reset: self calibration mode, bipolar, all else 0
`define ACR_CTRL_RESET     24'h000300

// calibration duration in nanoseconds and in core cycles (rounded up)
`define ACR_CAL_NS         2000
`define ACR_CAL_CYCLES     ((`ACR_CAL_NS * 1000 + `ACR_CLK_PS - 1) / `ACR_CLK_PS)

`endif

// ==== rtl/acr_sync.v ====
// acr_sync.v - two flip-flop synchroniser for a group of pin inputs.
// assumes the inputs are asynchronous to clk_in; only the second stage is
// meant to be read by logic.
`timescale 1ns/1ps
`default_nettype none

module acr_sync #(
   parameter WIDTH = 1
) (
   input  wire             clk_in,   // core clock
   input  wire             rst_in,   // synchronous reset, active high
   input  wire [WIDTH-1:0] async_in, // pins from outside the domain
   input  wire [WIDTH-1:0] rst_val_in, // constant level held in reset
   output reg  [WIDTH-1:0] sync_out  // synchronised copy
);

   reg [WIDTH-1:0] meta_q;

   // first stage feeds only the second
   always @(posedge clk_in) begin
      if (rst_in) begin
         meta_q   <= rst_val_in;
         sync_out <= rst_val_in;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

`default_nettype wire

// ==== rtl/acr_offset_apply.v ====
// acr_offset_apply.v - removes the offset coefficient from filter data so
// that a zero input reads as all zeros.
// assumes raw data and the strobe arrive on the core clock.
`timescale 1ns/1ps
`default_nettype none

module acr_offset_apply (
   input  wire        clk_in,       // core clock
   input  wire        rst_in,       // synchronous reset, active high
   input  wire        raw_valid_in, // raw filter word strobe
   input  wire [23:0] raw_data_in,  // raw filter word
   input  wire [23:0] offset_in,    // offset coefficient
   output reg         cor_valid_out, // corrected word strobe
   output reg  [23:0] cor_data_out  // corrected word
);

   // subtract offset, one cycle of latency
   always @(posedge clk_in) begin
      if (rst_in) begin
         cor_valid_out <= 1'b0;
         cor_data_out  <= 24'h000000;
      end else begin
         cor_valid_out <= raw_valid_in;
         if (raw_valid_in) begin
            cor_data_out <= raw_data_in - offset_in;
         end
      end
   end

endmodule

`default_nettype wire

// ==== rtl/acr_top.v ====
// acr_top.v - control word and calibration coefficient registers of the
// converter, reached over the serial port, with the result-valid output
// and the calibration sequencer.
// assumes the serial pins are asynchronous and slow against clk_in; the
// filter datapath and calibration engine sit on clk_in.
`include "acr_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module acr_top (
   input  wire        clk_in,             // core clock, 250 MHz
   input  wire        rst_in,             // external reset, active high
   input  wire        sclk_in,            // serial clock pin
   input  wire        cs_n_in,            // serial frame select, active low
   input  wire        sdio_in,            // serial data pin, input side
   output reg         sdio_out,           // serial data pin, output side
   output reg         sdio_oe_out,        // serial data drive enable
   input  wire [23:0] cal_offset_in,      // offset found by calibration
   input  wire [23:0] cal_posfs_in,       // positive full scale from calibration
   input  wire [23:0] cal_negfs_in,       // negative full scale from calibration
   input  wire        raw_valid_in,       // filter word strobe
   input  wire [23:0] raw_data_in,        // filter word
   input  wire        result_read_in,     // result has been read out
   output reg         result_valid_n_out, // result waiting, active low
   output reg         calibrating_out,    // calibration in progress
   output reg  [23:0] ctrl_word_out,      // control word
   output reg  [23:0] offset_coef_out,    // offset coefficient
   output reg  [23:0] posfs_coef_out,     // positive full-scale coefficient
   output reg  [23:0] negfs_coef_out,     // negative full-scale coefficient
   output wire        cor_valid_out,      // corrected word strobe
   output wire [23:0] cor_data_out        // corrected word
);

   localparam ST_CMD  = 2'h0;
   localparam ST_DATA = 2'h1;
   localparam ST_IDLE = 2'h2;

   localparam integer CAL_LEN_I = `ACR_CAL_CYCLES;
   localparam [15:0]  CAL_LEN   = CAL_LEN_I[15:0];

   wire [2:0] pins_s;
   wire       sclk_s;
   wire       cs_n_s;
   wire       sdio_s;

   reg        sclk_prev_q;
   reg        cs_n_prev_q;
   reg  [1:0] state_q;
   reg  [2:0] bit_cnt_q;
   reg  [7:0] shift_q;
   reg  [7:0] tx_q;
   reg        rd_q;
   reg  [1:0] left_q;
   reg  [1:0] idx_q;
   reg  [2:0] sel_q;
   reg        upper_hit_q;
   reg        cal_run_q;
   reg        cal_req_q;
   reg        cal_self_q;
   reg [15:0] cal_cnt_q;

   wire       sclk_rise;
   wire       sclk_fall;
   wire       frame_end;
   wire [7:0] rx_byte;
   wire       byte_done;
   wire [2:0] mode;
   wire       asc;
   wire [1:0] idx_next;
   wire [7:0] rd_byte;
   wire [2:0] cmd_sel;
   wire [1:0] cmd_idx;

   // pins into the core clock domain
   acr_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk_in     (clk_in),
      .rst_in     (rst_in),
      .async_in   ({sclk_in, cs_n_in, sdio_in}),
      .rst_val_in (3'h2),
      .sync_out   (pins_s)
   );

   assign sclk_s = pins_s[2];
   assign cs_n_s = pins_s[1];
   assign sdio_s = pins_s[0];

   // edges of the sampled serial clock and select
   assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
   assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
   assign frame_end = cs_n_s & ~cs_n_prev_q;
   assign rx_byte   = {shift_q[6:0], sdio_s};
   assign byte_done = sclk_rise & (bit_cnt_q == 3'h7);

   // control fields and byte walk direction
   assign mode     = ctrl_word_out[`ACR_MODE_HI:`ACR_MODE_LO];
   assign asc      = ctrl_word_out[`ACR_BYTE_ORDER_BIT];
   assign idx_next = asc ? idx_q + 2'h1 : idx_q - 2'h1;
   assign cmd_sel  = rx_byte[`ACR_CMD_REG_HI:`ACR_CMD_REG_LO];
   assign cmd_idx  = rx_byte[`ACR_CMD_IDX_HI:`ACR_CMD_IDX_LO];

   // pick one byte of a 24-bit register
   function [7:0] pick;
      input [23:0] word;
      input [1:0]  idx;
      begin
         case (idx)
            2'h0:    pick = word[7:0];
            2'h1:    pick = word[15:8];
            2'h2:    pick = word[23:16];
            default: pick = 8'h00;
         endcase
      end
   endfunction

   // replace one byte of a 24-bit register
   function [23:0] poke;
      input [23:0] word;
      input [1:0]  idx;
      input [7:0]  val;
      begin
         case (idx)
            2'h0:    poke = {word[23:8], val};
            2'h1:    poke = {word[23:16], val, word[7:0]};
            2'h2:    poke = {val, word[15:0]};
            default: poke = word;
         endcase
      end
   endfunction

   // read byte for a register select and byte index
   function [7:0] rd_mux;
      input [2:0] sel;
      input [1:0] idx;
      begin
         case (sel)
            `ACR_REG_CTRL:   rd_mux = pick(ctrl_word_out, idx);
            `ACR_REG_OFFSET: rd_mux = pick(offset_coef_out, idx);
            `ACR_REG_POSFS:  rd_mux = pick(posfs_coef_out, idx);
            `ACR_REG_NEGFS:  rd_mux = pick(negfs_coef_out, idx);
            default:         rd_mux = 8'h00;
         endcase
      end
   endfunction

   assign rd_byte = rd_mux(sel_q, idx_next);

   // serial frame: command byte, then data bytes, MSB first
   always @(posedge clk_in) begin
      if (rst_in) begin
         sclk_prev_q <= 1'b0;
         cs_n_prev_q <= 1'b1;
         state_q     <= ST_IDLE;
         bit_cnt_q   <= 3'h0;
         shift_q     <= 8'h00;
         tx_q        <= 8'h00;
         rd_q        <= 1'b0;
         left_q      <= 2'h0;
         idx_q       <= 2'h0;
         sel_q       <= 3'h0;
         sdio_out    <= 1'b0;
         sdio_oe_out <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
         cs_n_prev_q <= cs_n_s;
         if (cs_n_s) begin
            state_q     <= ST_CMD;
            bit_cnt_q   <= 3'h0;
            sdio_oe_out <= 1'b0;
         end else begin
            if (sclk_rise) begin
               shift_q   <= rx_byte;
               bit_cnt_q <= bit_cnt_q + 3'h1;
               tx_q      <= {tx_q[6:0], 1'b0};
            end
            // present the next read bit after the falling edge
            if (sclk_fall && state_q == ST_DATA && rd_q) begin
               sdio_out    <= tx_q[7];
               sdio_oe_out <= 1'b1;
            end
            if (byte_done) begin
               case (state_q)
                  ST_CMD: begin
                     rd_q    <= rx_byte[`ACR_CMD_RD_BIT];
                     left_q  <= rx_byte[`ACR_CMD_CNT_HI:`ACR_CMD_CNT_LO];
                     idx_q   <= cmd_idx;
                     sel_q   <= cmd_sel;
                     tx_q    <= rd_mux(cmd_sel, cmd_idx);
                     state_q <= ST_DATA;
                  end
                  ST_DATA: begin
                     idx_q <= idx_next;
                     tx_q  <= rd_byte;
                     if (left_q == 2'h0) begin
                        state_q <= ST_IDLE;
                     end else begin
                        left_q <= left_q - 2'h1;
                     end
                  end
                  default: begin
                     state_q <= ST_IDLE;
                  end
               endcase
            end
         end
      end
   end

   // register writes from the serial port and calibration loads
   always @(posedge clk_in) begin
      if (rst_in) begin
         ctrl_word_out   <= `ACR_CTRL_RESET;
         offset_coef_out <= 24'h000000;
         posfs_coef_out  <= 24'h000000;
         negfs_coef_out  <= 24'h000000;
         upper_hit_q     <= 1'b0;
      end else begin
         if (frame_end) begin
            upper_hit_q <= 1'b0;
         end
         if (byte_done && state_q == ST_DATA && !rd_q) begin
            case (sel_q)
               `ACR_REG_CTRL: begin
                  ctrl_word_out <= poke(ctrl_word_out, idx_q, rx_byte);
                  // byte 0 alone changes the gain without starting a calibration
                  if (idx_q != 2'h0) begin
                     upper_hit_q <= 1'b1;
                  end
               end
               `ACR_REG_OFFSET: offset_coef_out <= poke(offset_coef_out, idx_q, rx_byte);
               `ACR_REG_POSFS:  posfs_coef_out  <= poke(posfs_coef_out, idx_q, rx_byte);
               `ACR_REG_NEGFS:  negfs_coef_out  <= poke(negfs_coef_out, idx_q, rx_byte);
               default: begin
                  upper_hit_q <= upper_hit_q;
               end
            endcase
         end
         // self calibration result replaces all three coefficients
         if (cal_run_q && cal_cnt_q == 16'h0001 && cal_self_q) begin
            offset_coef_out <= cal_offset_in;
            posfs_coef_out  <= cal_posfs_in;
            negfs_coef_out  <= cal_negfs_in;
         end
      end
   end

   // calibration sequencer; reset starts a self calibration
   always @(posedge clk_in) begin
      if (rst_in) begin
         cal_req_q       <= 1'b1;
         cal_run_q       <= 1'b0;
         cal_self_q      <= 1'b0;
         cal_cnt_q       <= 16'h0000;
         calibrating_out <= 1'b0;
      end else begin
         // frame that touched byte 1 or 2 in a calibration mode
         if (frame_end && upper_hit_q && mode != `ACR_MODE_CONVERT
             && mode <= `ACR_MODE_CAL_LAST) begin
            cal_req_q <= 1'b1;
         end else if (cal_req_q && !ctrl_word_out[`ACR_STANDBY_BIT]) begin
            cal_req_q       <= 1'b0;
            cal_run_q       <= 1'b1;
            cal_self_q      <= (mode == `ACR_MODE_SELF_CAL);
            cal_cnt_q       <= CAL_LEN;
            calibrating_out <= 1'b1;
         end else if (cal_run_q) begin
            cal_cnt_q <= cal_cnt_q - 16'h0001;
            if (cal_cnt_q == 16'h0001) begin
               cal_run_q       <= 1'b0;
               calibrating_out <= 1'b0;
            end
         end
      end
   end

   // result valid: low on a fresh corrected word once idle
   always @(posedge clk_in) begin
      if (rst_in) begin
         result_valid_n_out <= 1'b1;
      end else if ((frame_end && upper_hit_q) || cal_req_q || cal_run_q
                   || ctrl_word_out[`ACR_STANDBY_BIT]) begin
         result_valid_n_out <= 1'b1;
      end else if (cor_valid_out) begin
         result_valid_n_out <= 1'b0;
      end else if (result_read_in) begin
         result_valid_n_out <= 1'b1;
      end
   end

   // offset removal on the filter output
   acr_offset_apply u_offset (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .raw_valid_in  (raw_valid_in),
      .raw_data_in   (raw_data_in),
      .offset_in     (offset_coef_out),
      .cor_valid_out (cor_valid_out),
      .cor_data_out  (cor_data_out)
   );

endmodule

`default_nettype wire

// ==== tb/acr_top_assertions.sv ====
// acr_top_assertions.sv - timing checks on the control and coefficient block
// assumes it is bound to acr_top; one clock domain, synchronous reset
`timescale 1ns/1ps
`default_nettype none
`include "acr_consts.vh"
module acr_top_assertions (
   input wire logic        clk_in,             // core clock
   input wire logic        rst_in,             // reset, active high
   input wire logic        cs_n_in,            // frame select
   input wire logic        raw_valid_in,       // filter word strobe
   input wire logic [23:0] raw_data_in,        // filter word
   input wire logic        result_read_in,     // result consumed
   input wire logic [23:0] cal_offset_in,      // calibrated offset
   input wire logic [23:0] cal_posfs_in,       // calibrated positive scale
   input wire logic [23:0] cal_negfs_in,       // calibrated negative scale
   input wire logic        sdio_oe_out,        // data pin drive enable
   input wire logic        result_valid_n_out, // result waiting, active low
   input wire logic        calibrating_out,    // calibration running
   input wire logic [23:0] ctrl_word_out,      // control word
   input wire logic [23:0] offset_coef_out,    // offset coefficient
   input wire logic [23:0] posfs_coef_out,     // positive coefficient
   input wire logic [23:0] negfs_coef_out,     // negative coefficient
   input wire logic        cor_valid_out,      // corrected strobe
   input wire logic [23:0] cor_data_out        // corrected word
);
   localparam int CAL_LO = `ACR_CAL_CYCLES - 1;
   localparam int CAL_HI = `ACR_CAL_CYCLES + 2;
   logic [10:0] cal_cnt_q;

   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // length of the running calibration
   always @(posedge clk_in) begin
      if (rst_in || !calibrating_out) cal_cnt_q <= 11'h000;
      else cal_cnt_q <= cal_cnt_q + 11'h001;
   end

   sequence s_cal_end;
      calibrating_out ##1 !calibrating_out;
   endsequence
   sequence s_result_made;
      cor_valid_out && !calibrating_out && !ctrl_word_out[`ACR_STANDBY_BIT] && !result_read_in;
   endsequence

   a_result_after_cor: assert property (s_result_made |=> !result_valid_n_out)
      else $error("result flag not set after corrected word");
   a_read_clears: assert property (result_read_in && !cor_valid_out |=> result_valid_n_out)
      else $error("result flag not cleared by read");
   a_cal_holds_ready: assert property (calibrating_out && $past(calibrating_out) |-> result_valid_n_out)
      else $error("result flag low during calibration");
   a_cal_length: assert property (s_cal_end |-> cal_cnt_q inside {[CAL_LO:CAL_HI]})
      else $error("calibration length wrong");
   a_coef_load: assert property (s_cal_end ##0 ctrl_word_out[11:9] == `ACR_MODE_SELF_CAL |->
      offset_coef_out == cal_offset_in && posfs_coef_out == cal_posfs_in
      && negfs_coef_out == cal_negfs_in)
      else $error("coefficients not loaded by self calibration");
   a_offset_apply: assert property (raw_valid_in |=> cor_valid_out
      && cor_data_out == $past(raw_data_in) - $past(offset_coef_out))
      else $error("offset correction wrong");
   a_reset_values: assert property ($fell(rst_in) |-> ctrl_word_out == `ACR_CTRL_RESET
      && result_valid_n_out && !calibrating_out)
      else $error("reset values wrong");
   a_oe_release: assert property (cs_n_in [*8] |-> !sdio_oe_out)
      else $error("data pin driven outside frame");
   a_upper_ready: assert property ($changed(ctrl_word_out[23:8]) |-> ##[0:600] result_valid_n_out)
      else $error("upper control write kept result flag low");
endmodule

bind acr_top acr_top_assertions u_chk (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in),
   .raw_valid_in(raw_valid_in), .raw_data_in(raw_data_in), .result_read_in(result_read_in),
   .cal_offset_in(cal_offset_in), .cal_posfs_in(cal_posfs_in), .cal_negfs_in(cal_negfs_in),
   .sdio_oe_out(sdio_oe_out), .result_valid_n_out(result_valid_n_out),
   .calibrating_out(calibrating_out), .ctrl_word_out(ctrl_word_out),
   .offset_coef_out(offset_coef_out), .posfs_coef_out(posfs_coef_out),
   .negfs_coef_out(negfs_coef_out), .cor_valid_out(cor_valid_out), .cor_data_out(cor_data_out));
`default_nettype wire

// ==== tb/acr_host_model.sv ====
// acr_host_model.sv - host side of the serial port, behavioural
// assumes a 125 ns serial clock, idle low, still outside frames
`timescale 1ns/1ps
`default_nettype none
module acr_host_model (
   output var logic sclk_out,  // serial clock
   output var logic cs_n_out,  // frame select
   output var logic sd_out,    // data driven by host
   output var logic sd_oe_out, // host drives data
   input wire logic sd_in      // resolved data line
);
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      sd_out = 1'b0;
      sd_oe_out = 1'b0;
   end

   // one frame: command then n bytes, msb first, first byte topmost
   task automatic xfer(input logic [7:0] cmd, input int n, input logic [23:0] wd,
                       output logic [23:0] rd);
      logic [31:0] sh;
      sh = {cmd, wd};
      rd = 24'h0;
      cs_n_out = 1'b0;
      #62.5;
      for (int i = 0; i < 8 * (n + 1); i++) begin
         sclk_out = 1'b0;
         sd_oe_out = !(cmd[7] && i >= 8);
         sd_out = sh[31-i];
         #62.5 sclk_out = 1'b1;
         if (i >= 8) rd[31-i] = sd_in;
         #62.5;
      end
      sclk_out = 1'b0;
      sd_oe_out = 1'b0;
      #62.5 cs_n_out = 1'b1;
      #250;
   endtask
endmodule
`default_nettype wire

// ==== tb/acr_top_tb.sv ====
// acr_top_tb.sv - self-checking bench for the control and coefficient block
// assumes acr_top, the host model and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
`include "acr_consts.vh"
module acr_top_tb;
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        sclk_in, cs_n_in, sdio_out, sdio_oe_out, host_d, host_oe;
   logic        sdio_last = 1'b0;
   logic        cal_prev = 1'b0;
   logic [15:0] cal_len = 16'h0;
   logic        raw_valid_in = 1'b0;
   logic        result_read_in = 1'b0;
   logic        result_valid_n_out, calibrating_out, cor_valid_out;
   logic [23:0] raw_data_in = 24'h0;
   logic [23:0] cal_offset_in = 24'h00A5C3;
   logic [23:0] cal_posfs_in = 24'h7F1234;
   logic [23:0] cal_negfs_in = 24'h80ABCD;
   logic [23:0] ctrl_word_out, offset_coef_out, posfs_coef_out, negfs_coef_out;
   logic [23:0] cor_data_out, rd;
   int          err_count = 0;
   int          check_count = 0;
   int          cycles = 0;
   // released line shows a changing pattern, never the last value
   wire sdio_in = sdio_oe_out ? sdio_out : (host_oe ? host_d : ~sdio_last);

   always #2 clk_in = ~clk_in;
   // last line level, length of the latest calibration run and run ceiling
   always @(posedge clk_in) begin
      sdio_last <= sdio_in;
      cycles <= cycles + 1;
      cal_prev <= calibrating_out;
      if (calibrating_out) cal_len <= cal_prev ? cal_len + 16'h1 : 16'h1;
      if (cycles == 60000) begin
         err_count = err_count + 1;
         print_verdict();
      end
   end

   acr_host_model HOST (.sclk_out(sclk_in), .cs_n_out(cs_n_in), .sd_out(host_d),
      .sd_oe_out(host_oe), .sd_in(sdio_in));
   acr_top DUT (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
      .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_out(sdio_oe_out),
      .cal_offset_in(cal_offset_in), .cal_posfs_in(cal_posfs_in), .cal_negfs_in(cal_negfs_in),
      .raw_valid_in(raw_valid_in), .raw_data_in(raw_data_in), .result_read_in(result_read_in),
      .result_valid_n_out(result_valid_n_out), .calibrating_out(calibrating_out),
      .ctrl_word_out(ctrl_word_out), .offset_coef_out(offset_coef_out),
      .posfs_coef_out(posfs_coef_out), .negfs_coef_out(negfs_coef_out),
      .cor_valid_out(cor_valid_out), .cor_data_out(cor_data_out));

   task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
      check_count = check_count + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic print_verdict();
      if (err_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // waits for a calibration to start and end, bounded
   task automatic wait_cal();
      int k;
      k = 0;
      while (calibrating_out !== 1'b1 && k < 100) begin
         @(negedge clk_in);
         k++;
      end
      check("cal_start", 24'h1, {23'h0, calibrating_out});
      while (calibrating_out !== 1'b0 && k < 2000) begin
         @(negedge clk_in);
         k++;
      end
      check("cal_len", `ACR_CAL_CYCLES, {8'h0, cal_len});
   endtask

   task automatic pulse_raw(input logic [23:0] d);
      @(negedge clk_in);
      raw_valid_in = 1'b1;
      raw_data_in = d;
      @(negedge clk_in);
      raw_valid_in = 1'b0;
      @(negedge clk_in);
   endtask

   task automatic t_reset();
      repeat (10) @(negedge clk_in);
      check("ctrl_rst", `ACR_CTRL_RESET, ctrl_word_out);
      check("rdy_rst", 24'h1, {23'h0, result_valid_n_out});
      rst_in = 1'b0;
      wait_cal();
      check("off_cal", cal_offset_in, offset_coef_out);
      check("pos_cal", cal_posfs_in, posfs_coef_out);
      check("neg_cal", cal_negfs_in, negfs_coef_out);
      HOST.xfer(8'hD4, 3, 24'h0, rd);
      check("ctrl_rd", `ACR_CTRL_RESET, rd);
   endtask

   task automatic t_coefs();
      logic [23:0] v;
      for (int s = 5; s <= 7; s++) begin
         v = {5'h10, 3'(s), 16'h3CC3};
         HOST.xfer({1'b0, 2'd2, 2'd2, 3'(s)}, 3, v, rd);
         HOST.xfer({1'b1, 2'd2, 2'd2, 3'(s)}, 3, 24'h0, rd);
         check("coef_rd", v, rd);
      end
      check("off_port", 24'h853CC3, offset_coef_out);
      check("pos_port", 24'h863CC3, posfs_coef_out);
      check("neg_port", 24'h873CC3, negfs_coef_out);
      HOST.xfer(8'h8D, 1, 24'h0, rd);
      check("coef_b1", 24'h3C0000, rd);
      HOST.xfer(8'h53, 3, 24'hFFFFFF, rd);
      HOST.xfer(8'h83, 1, 24'h0, rd);
      check("unmapped", 24'h0, rd);
   endtask

   task automatic t_result();
      pulse_raw(24'h900000);
      check("cor", 24'h900000 - 24'h853CC3, cor_data_out);
      check("rdy_low", 24'h0, {23'h0, result_valid_n_out});
      result_read_in = 1'b1;
      @(negedge clk_in);
      result_read_in = 1'b0;
      check("rdy_read", 24'h1, {23'h0, result_valid_n_out});
      pulse_raw(24'h000001);
      // gain change by low byte alone, host then rewrites all bytes
      HOST.xfer(8'h04, 1, 24'hA00000, rd);
      check("gain", 24'h0003A0, ctrl_word_out);
      check("no_cal", 24'h0, {22'h0, calibrating_out, result_valid_n_out});
      HOST.xfer(8'h54, 3, 24'h0001A0, rd);
      check("conv_rdy", 24'h1, {22'h0, calibrating_out, result_valid_n_out});
      pulse_raw(24'h000002);
      cal_offset_in = 24'h000123;
      cal_posfs_in = 24'h654321;
      cal_negfs_in = 24'h9ABCDE;
      HOST.xfer(8'h54, 3, 24'h0003A0, rd);
      wait_cal();
      check("cal_rdy", 24'h1, {23'h0, result_valid_n_out});
      check("off_new", 24'h000123, offset_coef_out);
      pulse_raw(24'h000123);
      check("zero", 24'h0, cor_data_out);
      check("rdy_cal", 24'h0, {23'h0, result_valid_n_out});
   endtask

   task automatic t_order();
      HOST.xfer(8'h54, 3, 24'h000104, rd);
      HOST.xfer(8'h46, 3, 24'h112233, rd);
      check("asc_wr", 24'h332211, posfs_coef_out);
      HOST.xfer(8'hC6, 3, 24'h0, rd);
      check("asc_rd", 24'h112233, rd);
      // second calibration mode: runs, but leaves the coefficients alone
      HOST.xfer(8'h44, 3, 24'h040500, rd);
      check("sys_mode", 24'h000504, ctrl_word_out);
      wait_cal();
      check("sys_keep", 24'h332211, posfs_coef_out);
   endtask

   // external reset in mid-run reloads the self calibration results
   task automatic t_rerst();
      @(negedge clk_in);
      rst_in = 1'b1;
      repeat (10) @(negedge clk_in);
      check("ctrl_rst2", `ACR_CTRL_RESET, ctrl_word_out);
      rst_in = 1'b0;
      wait_cal();
      check("off_rst2", cal_offset_in, offset_coef_out);
      check("pos_rst2", cal_posfs_in, posfs_coef_out);
      check("neg_rst2", cal_negfs_in, negfs_coef_out);
   endtask

   initial begin
      t_reset();
      t_coefs();
      t_result();
      t_order();
      t_rerst();
      print_verdict();
   end
endmodule
`default_nettype wire
